// >>> shared/bps_defs.vh
/*
  Constants for the battery profile selector: command code, status bits,
  thresholds in measurement units and timing counts.
  Assumes measurements arrive as unsigned mV, mA and 0.1 degC codes.
*/
`ifndef BPS_DEFS_VH
`define BPS_DEFS_VH
`define BPS_CMD_PROFILE_STATUS  8'h6A
`define BPS_BIT_LAST_USED       0
`define BPS_BIT_UNSUPPORTED     1
`define BPS_STATUS_RESET        8'h00
`define BPS_TEMP_LOW_DC         16'h0032
`define BPS_TEMP_HIGH_DC        16'h01C2
`define BPS_TEMP_STEP_DC        16'h0050
`define BPS_CAL_CURR_MA         16'h0064
`define BPS_CAL_VSTEP_MV        16'h0100
`define BPS_CAL_VDROP_MV        16'h0020
`define BPS_TEMP_HOLD_S         34'h00000003C
`define BPS_CLK_HZ              34'h00BEBC200
`define BPS_TEMP_HOLD_CYC       (`BPS_TEMP_HOLD_S * `BPS_CLK_HZ)
`define BPS_CAL_CYC             16'h0100
`define BPS_NPROF               4
`endif

// >>> src/bps_profile_mem.v
/*
  Impedance store for two default and two dynamic profiles.
  Assumes one write and one read per cycle; read data is registered.
*/
`timescale 1ns/1ps
module bps_profile_mem (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        arst_n_i,
  // Write port
  input  wire        wr_en_i,
  input  wire [1:0]  wr_addr_i,
  input  wire [15:0] wr_data_i,
  // Read port
  input  wire [1:0]  rd_addr_i,
  output reg  [15:0] rd_data_o
);
  reg [15:0] mem [0:3];
  integer i;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
      rd_data_o <= 16'h0000;
    end else begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule

// >>> src/bps_top.v
/*
  Offset autocalibration control and pack-insertion profile selection.
  Assumes measurement inputs are already synchronous to core_clk_i;
  pin-level inputs are passed through two flip-flops.
*/
// Overview of operation
// - Calibrate offset on sleep entry unless temperature at or beyond 5/45 degC.
// - Single calibration when current low and voltage or temperature drifted.
// - Subtract measured offset from sense voltage before current use.
// - During calibration keep reporting last measured current.
// - Abort calibration when battery voltage drops more than 32 mV.
// - Keep two default and two dynamic profiles.
// - Simple variant uses one fixed default profile.
// - Battery-good inactive at power-up until first open-circuit voltage taken.
// - Then drive battery-good, compute impedance, compare with stored profiles.
// - Status byte at command 0x6A: bit1 unsupported, bit0 last-used.
// - Simple variant copies default into dynamic on first insertion.
// - Simple variant re-insertion matches dynamic first, else overwrites oldest.
// - ID variant picks default profile from ID pin level.
// - ID level matches within a configurable percentage window.
// - Unmatched ID sets unsupported flag and stores measured ID voltage.
// - After default download, clear sealed encoding enable.
// - ID variant first insertion copies matching default into matching dynamic.
// - Same ID, impedance mismatch: copy default into other empty dynamic.
// - Both dynamic full, no impedance match: rewrite the dynamic profile that is not last-used.
// - Enter sleep only when enabled and mean current below sleep level.
`timescale 1ns/1ps
`include "bps_defs.vh"
module bps_top #(
  parameter [33:0] TEMP_HOLD_CYC = `BPS_TEMP_HOLD_CYC
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        arst_n_i,
  // Configuration
  input  wire        id_variant_i,
  input  wire        sleep_enable_i,
  input  wire [15:0] sleep_current_i,
  input  wire [15:0] z_tolerance_i,
  input  wire [6:0]  id_window_pct_i,
  input  wire [15:0] id_level_a_i,
  input  wire [15:0] id_level_b_i,
  // Measurements
  input  wire [15:0] temperature_i,
  input  wire [15:0] voltage_i,
  input  wire [15:0] mean_current_value_i,
  input  wire [15:0] sense_resistor_voltage_i,
  input  wire [15:0] load_current_i,
  input  wire [15:0] id_resistor_pin_i,
  input  wire        meas_valid_i,
  // Pack and host events
  input  wire        pack_insert_i,
  input  wire        default_download_done_i,
  input  wire        default_write_i,
  input  wire [15:0] default_write_z_i,
  input  wire [7:0]  cmd_i,
  // Outputs
  output reg         battery_good_output_n_o,
  output reg         sleep_o,
  output reg         cal_busy_o,
  output reg  [15:0] corrected_sense_o,
  output reg  [15:0] id_voltage_store_o,
  output reg         sealed_encoding_enable_o,
  output reg  [1:0]  active_profile_o,
  output reg  [7:0]  read_data_o
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_OCV  = 3'h1;
  localparam [2:0] S_LOAD = 3'h2;
  localparam [2:0] S_RDA  = 3'h3;
  localparam [2:0] S_RDB  = 3'h4;
  localparam [2:0] S_RDD  = 3'h5;
  localparam [2:0] S_DEC  = 3'h6;
  localparam [2:0] S_RUN  = 3'h7;
  function [15:0] absdiff;
    input [15:0] a;
    input [15:0] b;
    absdiff = (a > b) ? a - b : b - a;
  endfunction
  function in_window;
    input [15:0] v;
    input [15:0] lvl;
    input [6:0]  pct;
    reg   [22:0] span;
    begin
      span = lvl * pct;
      in_window = ({7'h00, absdiff(v, lvl)} * 23'd100) <= span;
    end
  endfunction
  // Two-stage sync for the pin-level inputs
  reg        ins_s1, ins_s2, ins_s3;
  reg [15:0] rid_s1, rid_s2;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ins_s1 <= 1'b0;
      ins_s2 <= 1'b0;
      ins_s3 <= 1'b0;
      rid_s1 <= 16'h0000;
      rid_s2 <= 16'h0000;
    end else begin
      ins_s1 <= pack_insert_i;
      ins_s2 <= ins_s1;
      ins_s3 <= ins_s2;
      rid_s1 <= id_resistor_pin_i;
      rid_s2 <= rid_s1;
    end
  end
  wire insert_rise = ins_s2 & ~ins_s3;
  // Calibration control
  reg [15:0] offset, last_cal_v, last_cal_t, cal_start_v, last_current;
  reg [15:0] cal_cnt;
  reg [33:0] tdrift_cnt;
  wire cur_low    = mean_current_value_i <= `BPS_CAL_CURR_MA;
  wire temp_ok    = (temperature_i > `BPS_TEMP_LOW_DC) && (temperature_i < `BPS_TEMP_HIGH_DC);
  wire sleep_qual = sleep_enable_i && (mean_current_value_i < sleep_current_i);
  wire tdrift     = absdiff(temperature_i, last_cal_t) > `BPS_TEMP_STEP_DC;
  wire drift_go   = cur_low && ((absdiff(voltage_i, last_cal_v) >= `BPS_CAL_VSTEP_MV) ||
                    (tdrift_cnt >= TEMP_HOLD_CYC));
  wire sleep_go   = sleep_qual && !sleep_o && temp_ok;
  wire v_sag      = (cal_start_v > voltage_i) && (cal_start_v - voltage_i > `BPS_CAL_VDROP_MV);
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_busy_o <= 1'b0;
      sleep_o <= 1'b0;
      cal_cnt <= 16'h0000;
      offset <= 16'h0000;
      last_cal_v <= 16'h0000;
      last_cal_t <= 16'h0000;
      cal_start_v <= 16'h0000;
      tdrift_cnt <= 34'h000000000;
      last_current <= 16'h0000;
      corrected_sense_o <= 16'h0000;
    end else begin
      // Saturates so a long excursion cannot wrap below the hold time
      if (!tdrift) begin
        tdrift_cnt <= 34'h000000000;
      end else if (tdrift_cnt < TEMP_HOLD_CYC) begin
        tdrift_cnt <= tdrift_cnt + 34'h000000001;
      end
      if (cal_busy_o) begin
        cal_cnt <= cal_cnt + 16'h0001;
        if (v_sag) begin
          cal_busy_o <= 1'b0;
        end else if (cal_cnt == `BPS_CAL_CYC) begin
          cal_busy_o <= 1'b0;
          offset     <= sense_resistor_voltage_i;
          last_cal_v <= voltage_i;
          last_cal_t <= temperature_i;
          tdrift_cnt <= 34'h000000000;
          if (sleep_qual) sleep_o <= 1'b1;
        end
      end else if (sleep_go || drift_go) begin
        cal_busy_o  <= 1'b1;
        cal_cnt     <= 16'h0000;
        cal_start_v <= voltage_i;
      end else begin
        // Sleep entry without calibration when too hot or cold
        sleep_o <= sleep_qual && (sleep_o || !temp_ok);
      end
      if (!cal_busy_o && meas_valid_i) begin
        last_current      <= sense_resistor_voltage_i - offset;
        corrected_sense_o <= sense_resistor_voltage_i - offset;
      end else begin
        corrected_sense_o <= last_current;
      end
    end
  end
  // Profile store: 0,1 default a/b; 2,3 dynamic a/b
  reg        mem_we;
  reg [1:0]  mem_wa, mem_ra;
  reg [15:0] mem_wd;
  wire [15:0] mem_rd;
  bps_profile_mem u_mem (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .wr_en_i    (mem_we),
    .wr_addr_i  (mem_wa),
    .wr_data_i  (mem_wd),
    .rd_addr_i  (mem_ra),
    .rd_data_o  (mem_rd)
  );
  reg [2:0]  state;
  reg [15:0] ocv, z_meas, z_dyn_a, z_dyn_b, z_def;
  reg [1:0]  dyn_full;
  reg        last_used;
  reg        unsupported;
  reg        id_sel;
  reg        copy_pend;
  wire       id_a  = in_window(rid_s2, id_level_a_i, id_window_pct_i);
  wire       id_b  = in_window(rid_s2, id_level_b_i, id_window_pct_i);
  wire       m_a   = dyn_full[0] && absdiff(z_meas, z_dyn_a) <= z_tolerance_i;
  wire       m_b   = dyn_full[1] && absdiff(z_meas, z_dyn_b) <= z_tolerance_i;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= S_IDLE;
      battery_good_output_n_o <= 1'b1;
      ocv <= 16'h0000;
      z_meas <= 16'h0000;
      z_dyn_a <= 16'h0000;
      z_dyn_b <= 16'h0000;
      z_def <= 16'h0000;
      dyn_full <= 2'b00;
      last_used <= 1'b0;
      unsupported <= 1'b0;
      id_sel <= 1'b0;
      copy_pend <= 1'b0;
      id_voltage_store_o <= 16'h0000;
      sealed_encoding_enable_o <= 1'b1;
      active_profile_o <= 2'b10;
      mem_we <= 1'b0;
      mem_wa <= 2'b00;
      mem_ra <= 2'b00;
      mem_wd <= 16'h0000;
    end else begin
      mem_we <= default_write_i;
      mem_wa <= {1'b0, ~last_used};
      mem_wd <= default_write_z_i;
      if (default_download_done_i) sealed_encoding_enable_o <= 1'b0;
      case (state)
        S_IDLE: begin
          battery_good_output_n_o <= 1'b1;
          if (insert_rise) state <= S_OCV;
        end
        S_OCV: if (meas_valid_i) begin
          ocv    <= voltage_i;
          state  <= S_LOAD;
          battery_good_output_n_o <= 1'b0;
        end
        S_LOAD: if (meas_valid_i && load_current_i != 16'h0000) begin
          z_meas <= (ocv > voltage_i) ? (ocv - voltage_i) / load_current_i : 16'h0000;
          id_sel <= id_variant_i & id_b & ~id_a;
          mem_ra <= 2'd2;
          state  <= S_RDA;
        end
        S_RDA: begin
          mem_ra <= 2'd3;
          state  <= S_RDB;
        end
        S_RDB: begin
          z_dyn_a <= mem_rd;
          // Simple variant always uses default a
          mem_ra  <= id_variant_i ? {1'b0, id_sel} : 2'd0;
          state   <= S_RDD;
        end
        S_RDD: begin
          z_dyn_b <= mem_rd;
          state   <= S_DEC;
        end
        S_DEC: begin
          z_def <= mem_rd;
          state <= S_RUN;
          copy_pend <= 1'b0;
          unsupported <= 1'b0;
          if (id_variant_i && !id_a && !id_b) begin
            unsupported        <= 1'b1;
            id_voltage_store_o <= rid_s2;
          end else if (!id_variant_i) begin
            if (m_a) begin
              last_used <= 1'b0;
            end else if (m_b) begin
              last_used <= 1'b1;
            end else begin
              last_used <= (dyn_full == 2'b00) ? 1'b0 : ~last_used;
              copy_pend <= 1'b1;
            end
          end else if (dyn_full == 2'b00) begin
            last_used <= id_sel;
            copy_pend <= 1'b1;
          end else if (m_a || m_b) begin
            // A stored pack matches: use it; if both match, the ID level breaks the tie
            last_used <= m_b && (!m_a || id_sel);
          end else if (dyn_full != 2'b11) begin
            last_used <= ~dyn_full[1];
            copy_pend <= 1'b1;
          end else begin
            last_used <= ~last_used;
            copy_pend <= 1'b1;
          end
        end
        default: begin
          if (copy_pend) begin
            mem_we    <= 1'b1;
            mem_wa    <= {1'b1, last_used};
            mem_wd    <= z_def;
            dyn_full[last_used] <= 1'b1;
            copy_pend <= 1'b0;
          end
          active_profile_o <= {1'b1, last_used};
          if (!ins_s2) state <= S_IDLE;
        end
      endcase
    end
  end
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_data_o <= `BPS_STATUS_RESET;
    end else if (cmd_i == `BPS_CMD_PROFILE_STATUS) begin
      read_data_o <= {6'h00, unsupported, last_used};
    end else begin
      read_data_o <= 8'h00;
    end
  end
endmodule

// >>> tb/bps_sva.sv
/* Port checker for bps_top: status reads, calibration, sleep, seal.
   Assumes one clock domain and the async low reset. */
`timescale 1ns/1ps
module bps_sva (
  // Clock and reset
  input wire        core_clk_i, arst_n_i,
  // Inputs watched
  input wire        default_download_done_i, meas_valid_i, sleep_enable_i,
  input wire [7:0]  cmd_i,
  input wire [15:0] voltage_i,
  // Outputs watched
  input wire        sealed_encoding_enable_o, cal_busy_o, battery_good_output_n_o, sleep_o,
  input wire [7:0]  read_data_o,
  input wire [15:0] corrected_sense_o,
  input wire [1:0]  active_profile_o
);
  reg [15:0] cal_v;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Voltage frozen at calibration start
  always @(posedge core_clk_i) if (!cal_busy_o) cal_v <= voltage_i;
  a_other_cmd: assert property (cmd_i != 8'h6A |=> read_data_o == 8'h00)
    else $error("nonzero read");
  a_seal_clear: assert property (default_download_done_i |-> ##[1:3] !sealed_encoding_enable_o)
    else $error("seal kept");
  a_cal_abort: assert property (cal_busy_o && voltage_i + 16'h0021 <= cal_v |-> ##[1:3] !cal_busy_o)
    else $error("no abort");
  a_cal_length: assert property ($rose(cal_busy_o) |-> cal_busy_o [*8])
    else $error("short cal");
  a_cal_freeze: assert property (cal_busy_o && $past(cal_busy_o) |-> $stable(corrected_sense_o))
    else $error("current moved");
  a_good_cause: assert property ($fell(battery_good_output_n_o) |->
    $past(meas_valid_i) || $past(meas_valid_i, 2)) else $error("early good");
  a_sleep_gate: assert property ($rose(sleep_o) |-> $past(sleep_enable_i))
    else $error("sleep not enabled");
  a_dyn_active: assert property ($changed(active_profile_o) |-> !battery_good_output_n_o)
    else $error("profile switched while pack open");
  c_cal: cover property ($fell(cal_busy_o));
  c_sleep: cover property ($rose(sleep_o));
  c_seal: cover property ($fell(sealed_encoding_enable_o));
endmodule
bind bps_top bps_sva i_sva (
  .core_clk_i               (core_clk_i),
  .arst_n_i                 (arst_n_i),
  .default_download_done_i  (default_download_done_i),
  .meas_valid_i             (meas_valid_i),
  .sleep_enable_i           (sleep_enable_i),
  .cmd_i                    (cmd_i),
  .voltage_i                (voltage_i),
  .sealed_encoding_enable_o (sealed_encoding_enable_o),
  .cal_busy_o               (cal_busy_o),
  .battery_good_output_n_o  (battery_good_output_n_o),
  .sleep_o                  (sleep_o),
  .read_data_o              (read_data_o),
  .corrected_sense_o        (corrected_sense_o),
  .active_profile_o         (active_profile_o)
);

// >>> tb/bps_host_model.sv
/* Host model: reads a command code, downloads a default on an unsupported pack.
   Assumes one bench request at a time. */
`timescale 1ns/1ps
module bps_host_model (
  // Clock and bench side
  input  wire        core_clk_i,
  input  wire        req_i,
  input  wire [7:0]  code_i,
  output reg  [7:0]  resp_o,
  output reg         ack_o,
  // Device side
  input  wire [7:0]  read_data_i,
  output reg  [7:0]  cmd_o,
  output reg         dl_write_o,
  output reg  [15:0] dl_z_o,
  output reg         dl_done_o
);
  reg [2:0] step;
  initial begin
    {step, resp_o, ack_o, cmd_o, dl_write_o, dl_done_o} = 22'h0;
    dl_z_o = 16'h0005;
  end
  // Slot choice is left to the device via the last-used bit
  always @(posedge core_clk_i) begin
    ack_o <= 1'b0;
    dl_write_o <= 1'b0;
    dl_done_o <= 1'b0;
    case (step)
      3'd0: if (req_i) begin
        cmd_o <= code_i;
        step <= 3'd1;
      end
      3'd1: step <= 3'd2;
      3'd2: begin
        resp_o <= read_data_i;
        ack_o <= 1'b1;
        cmd_o <= 8'h00;
        step <= (code_i == 8'h6A && read_data_i[1]) ? 3'd3 : 3'd0;
      end
      3'd3: begin
        dl_write_o <= 1'b1;
        step <= 3'd4;
      end
      default: begin
        dl_done_o <= 1'b1;
        step <= 3'd0;
      end
    endcase
  end
endmodule

// >>> tb/tb_top.sv
/* Bench for bps_top: insertion rows, re-insertion, calibration, sleep.
   Assumes bps_host_model serves status reads and downloads. */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic v; logic [15:0] p; logic [1:0] a; logic [7:0] s;} bps_row_t;
  // Variant, ID pin mV, active profile (0 skips), status byte
  bps_row_t rows [0:5] = '{'{1'b0, 16'h0000, 2'h2, 8'h00}, '{1'b1, 16'h006E, 2'h2, 8'h00},
    '{1'b1, 16'h042E, 2'h3, 8'h01}, '{1'b1, 16'h0076, 2'h2, 8'h00}, '{1'b1, 16'h01F4, 2'h0, 8'h02},
    '{1'b1, 16'h007F, 2'h0, 8'h02}};
  reg clk = 1'b0, rst_n = 1'b0, se = 1'b0, mv = 1'b0, pk = 1'b0, req = 1'b0;
  reg [15:0] tmp = 16'h00FA, volt = 16'h0FA0, srv = 16'h0040, lc = 16'h0000, pin = 16'h0000, mc = 16'h0032;
  reg [7:0] code = 8'h6A;
  reg [15:0] sc = 16'h00C8, zt = 16'h0002;
  reg vr = 1'b0;
  wire [7:0] cmd, rdat, resp;
  wire [15:0] cs, idst, dz;
  wire [1:0] act;
  wire ack, dw, dd, bgn, slp, cal, seal;
  integer err_total = 0, samples_checked = 0, i;
  bps_top #(.TEMP_HOLD_CYC(34'h000000032)) i_dut (.core_clk_i(clk), .arst_n_i(rst_n), .id_variant_i(vr),
    .sleep_enable_i(se), .sleep_current_i(sc), .z_tolerance_i(zt), .id_window_pct_i(7'h0A),
    .id_level_a_i(16'h006E), .id_level_b_i(16'h042E), .temperature_i(tmp), .voltage_i(volt),
    .mean_current_value_i(mc), .sense_resistor_voltage_i(srv), .load_current_i(lc), .id_resistor_pin_i(pin),
    .meas_valid_i(mv), .pack_insert_i(pk), .default_download_done_i(dd), .default_write_i(dw),
    .default_write_z_i(dz), .cmd_i(cmd), .battery_good_output_n_o(bgn), .sleep_o(slp), .cal_busy_o(cal),
    .corrected_sense_o(cs), .id_voltage_store_o(idst), .sealed_encoding_enable_o(seal),
    .active_profile_o(act), .read_data_o(rdat));
  bps_host_model i_host (.core_clk_i(clk), .req_i(req), .code_i(code), .resp_o(resp), .ack_o(ack),
    .read_data_i(rdat), .cmd_o(cmd), .dl_write_o(dw), .dl_z_o(dz), .dl_done_o(dd));
  always #2.5 clk = ~clk;
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task rd(input [7:0] c, input [7:0] e);
    integer k;
    code <= c;
    req <= 1'b1;
    tick(1);
    req <= 1'b0;
    for (k = 0; k < 20 && ack !== 1'b1; k = k + 1) tick(1);
    chk({15'h0, ack}, 16'h0001);
    chk({8'h00, resp}, {8'h00, e});
  endtask
  task rst;
    rst_n <= 1'b0;
    pk <= 1'b0;
    se <= 1'b0;
    srv <= 16'h0040;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
  endtask
  // Removal, insertion, open-circuit sample, then loaded sample at 100 mA
  task ins(input v, input [15:0] p, input [15:0] lv);
    pk <= 1'b0;
    tick(4);
    vr <= v;
    pin <= p;
    pk <= 1'b1;
    tick(8);
    volt <= 16'h0FA0;
    lc <= 16'h0000;
    mv <= 1'b1;
    tick(1);
    mv <= 1'b0;
    tick(2);
    volt <= lv;
    lc <= 16'h0064;
    mv <= 1'b1;
    tick(1);
    mv <= 1'b0;
    tick(12);
  endtask
  task cal_run(input [15:0] t, input drop, input exp_cal);
    integer k, st, len;
    st = -1;
    len = 0;
    rst;
    tmp <= t;
    ins(1'b0, 16'h0000, 16'h0F3C);
    // Let the drift calibration after reset run out first
    tick(260);
    se <= 1'b1;
    for (k = 0; k < 700; k = k + 1) begin
      tick(1);
      mv <= (k % 16 == 0);
      if (cal === 1'b1 && st < 0) st = k;
      if (st >= 0 && k == st + 5) srv <= 16'h0050;
      if (drop && st >= 0 && k == st + 20) volt <= 16'h0F14;
      if (st >= 0 && cal !== 1'b1 && len == 0) len = k - st;
    end
    chk({15'h0, st >= 0}, {15'h0, exp_cal});
    if (!drop) chk({15'h0, slp}, 16'h0001);
    if (drop) chk({15'h0, len > 0 && len < 30}, 16'h0001);
    else if (exp_cal) chk({15'h0, len >= 256}, 16'h0001);
    if (!drop && exp_cal) begin
      tick(1);
      srv <= 16'h0058;
      mv <= 1'b1;
      tick(1);
      mv <= 1'b0;
      tick(2);
      chk(cs, 16'h0008);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    chk({10'h000, bgn, seal, slp, cal, act}, 16'h0032);
    rd(8'h6B, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      rst;
      ins(rows[i].v, rows[i].p, 16'h0F3C);
      if (rows[i].a != 2'h0) chk({14'h0, act}, {14'h0, rows[i].a});
      rd(8'h6A, rows[i].s);
      if (rows[i].s[1]) begin
        tick(6);
        chk(idst, rows[i].p);
        chk({15'h0, seal}, 16'h0000);
      end
    end
    for (i = 0; i < 2; i = i + 1) begin
      rst;
      ins(i[0], 16'h006E, 16'h0F3C);
      chk({15'h0, bgn}, 16'h0000);
      ins(i[0], 16'h006E, 16'h0BB8);
      chk({14'h0, act}, 16'h0003);
      ins(i[0], 16'h006E, 16'h0F3C);
      chk({14'h0, act}, 16'h0002);
    end
    cal_run(16'h00FA, 1'b0, 1'b1);
    cal_run(16'h0032, 1'b0, 1'b0);
    cal_run(16'h01C2, 1'b0, 1'b0);
    cal_run(16'h00FA, 1'b1, 1'b1);
    print_verdict;
  end
endmodule
